/* File: bench/testbench.sv */
// self-checking testbench for the dac checksum and sense test block
`timescale 1ns/1ps
`include "dac_test_params.svh"
module testbench;
    // ****************************************
    // stimulus, observation and bookkeeping
    // ****************************************
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
    logic       ref_clk_i;
    logic       rst_n_i;
    logic [7:0] reg_index_i;
    logic [7:0] reg_wdata_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic [7:0] red_data_i;
    logic [7:0] green_data_i;
    logic [7:0] blue_data_i;
    logic       mux_i;
    logic       sys_bl_n;
    logic       leg_bl_n;
    logic       sys_hs_n;
    logic       leg_hs_n;
    logic       vs_n;
    logic [2:0] over;
    logic       sense_n_o;
    int         fails = 0;
    int         checked = 0;
    int         cycles = 0;

    dac_crc_sense_test #(.ID_CODE(ID_VAL)) uut
    (
        .ref_clk_i              (ref_clk_i),
        .rst_n_i                (rst_n_i),
        .reg_index_i            (reg_index_i),
        .reg_wdata_i            (reg_wdata_i),
        .reg_wr_i               (reg_wr_i),
        .reg_rd_i               (reg_rd_i),
        .reg_rdata_o            (reg_rdata_o),
        .red_data_i             (red_data_i),
        .green_data_i           (green_data_i),
        .blue_data_i            (blue_data_i),
        .mux_control_two_bit7_i (mux_i),
        .system_blank_in_n_i    (sys_bl_n),
        .legacy_blank_in_n_i    (leg_bl_n),
        .system_hsync_in_n_i    (sys_hs_n),
        .legacy_hsync_in_n_i    (leg_hs_n),
        .vert_sync_n_i          (vs_n),
        .red_over_i             (over[2]),
        .green_over_i           (over[1]),
        .blue_over_i            (over[0]),
        .sense_n_o              (sense_n_o)
    );

    // 25 ns dot clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // hang guard
    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk_i);
            #2;
        end
    endtask : tick

    task check_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : check_byte

    task check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t sense pin got %b exp %b", $time, got, exp);
        end
    endtask : check_bit

    task wr_reg(input logic [7:0] idx, input logic [7:0] d);
        reg_index_i = idx;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        tick(1);
    endtask : wr_reg

    task rd_check(input logic [7:0] idx, input logic [7:0] exp);
        reg_index_i = idx;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        tick(1);
        check_byte(reg_rdata_o, exp);
    endtask : rd_check

    // serial checksum step, msb first
    function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
        logic fb;
        fb = c[15] ^ b;
        return {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
    endfunction : crc_step

    // n unblanked cycles of a data pattern, then blank with junk data
    task active_area(input logic [4:0] sel, input int n,
                     input logic [7:0] base, inout logic [15:0] c);
        logic [23:0] pix;
        sys_bl_n = 1'b1;
        leg_bl_n = 1'b1;
        for (int k = 0; k < n; k++)
        begin
            pix = {8'(base + k * 3), 8'(base ^ k), 8'(k * 7 + 1)};
            {blue_data_i, green_data_i, red_data_i} = pix;
            c = crc_step(c, (sel <= 5'h17) ? pix[sel] : 1'b0);
            tick(1);
        end
        sys_bl_n = 1'b0;
        leg_bl_n = 1'b0;
        tick(1);
        {blue_data_i, green_data_i, red_data_i} = 24'hffffff;
        tick(6);
    endtask : active_area

    task hsync_pulse(input logic leg);
        if (leg)
            leg_hs_n = 1'b0;
        else
            sys_hs_n = 1'b0;
        tick(4);
        sys_hs_n = 1'b1;
        leg_hs_n = 1'b1;
        tick(6);
    endtask : hsync_pulse

    task retrace(input logic leg, input logic [15:0] old,
                 input logic [15:0] nw);
        vs_n = 1'b0;
        tick(4);
        hsync_pulse(leg);
        rd_check(`LOW_BYTE_IDX, old[7:0]);
        rd_check(`HIGH_BYTE_IDX, old[15:8]);
        hsync_pulse(leg);
        rd_check(`LOW_BYTE_IDX, nw[7:0]);
        rd_check(`HIGH_BYTE_IDX, nw[15:8]);
        vs_n = 1'b1;
        tick(4);
    endtask : retrace

    // one blank falling edge on the chosen pin with comparators set
    task capture(input logic [2:0] v, input logic leg);
        over = v;
        if (leg)
            leg_bl_n = 1'b1;
        else
            sys_bl_n = 1'b1;
        tick(4);
        sys_bl_n = 1'b0;
        leg_bl_n = 1'b0;
        tick(6);
    endtask : capture

    // ****************************************
    // scenarios
    // ****************************************
    task test_reset_values;
        rd_check(`LINE_SEL_IDX, 8'h00);
        rd_check(`SENSE_IDX, 8'h00);
        rd_check(`LOW_BYTE_IDX, 8'h00);
        check_bit(sense_n_o, 1'b1);
        rd_check(`ID_IDX, ID_VAL);
        wr_reg(`ID_IDX, 8'hff);
        rd_check(`ID_IDX, ID_VAL);
        rd_check(8'h3e, 8'h00);
        wr_reg(`LINE_SEL_IDX, 8'h17);
        rd_check(`LINE_SEL_IDX, 8'h17);
    endtask : test_reset_values

    task test_crc;
        logic [15:0] c1;
        logic [15:0] c2;
        c1 = 16'h0000;
        c2 = 16'h0000;
        wr_reg(`LINE_SEL_IDX, 8'h09);
        active_area(5'h09, 30, 8'h21, c1);
        active_area(5'h09, 25, 8'h6b, c1);
        retrace(1'b0, 16'h0000, c1);
        mux_i = 1'b1;
        wr_reg(`LINE_SEL_IDX, 8'h17);
        active_area(5'h17, 40, 8'hc4, c2);
        retrace(1'b1, c1, c2);
        mux_i = 1'b0;
        tick(2);
        c1 = 16'h0000;
        wr_reg(`LINE_SEL_IDX, 8'h1f);
        active_area(5'h1f, 20, 8'h9d, c1);
        retrace(1'b0, c2, c1);
    endtask : test_crc

    task test_sense;
        logic [2:0] pats [5] = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b111};
        foreach (pats[i])
        begin
            capture(pats[i], 1'b0);
            rd_check(`SENSE_IDX, {5'h00, pats[i]});
            check_bit(sense_n_o, ~|pats[i]);
        end
        wr_reg(`SENSE_IDX, 8'h80);
        capture(3'b111, 1'b0);
        rd_check(`SENSE_IDX, 8'h80);
        check_bit(sense_n_o, 1'b1);
        wr_reg(`SENSE_IDX, 8'h00);
        capture(3'b001, 1'b0);
        rd_check(`SENSE_IDX, 8'h01);
        mux_i = 1'b1;
        tick(3);
        capture(3'b110, 1'b0);
        rd_check(`SENSE_IDX, 8'h01);
        capture(3'b110, 1'b1);
        rd_check(`SENSE_IDX, 8'h06);
        check_bit(sense_n_o, 1'b0);
    endtask : test_sense

    task report_and_stop;
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst_n_i = 1'b0;
        {reg_index_i, reg_wdata_i, reg_wr_i, reg_rd_i} = 18'h00000;
        {red_data_i, green_data_i, blue_data_i} = 24'h000000;
        {mux_i, sys_bl_n, leg_bl_n, over} = 6'h00;
        {sys_hs_n, leg_hs_n, vs_n} = 3'b111;
        repeat (3) @(posedge ref_clk_i);
        #2;
        rst_n_i = 1'b1;
        tick(3);
        test_reset_values();
        test_crc();
        test_sense();
        report_and_stop();
    end
endmodule : testbench

/* File: hdl/crc16_engine.sv */
// serial 16-bit checksum accumulator, x^16 + x^15 + x^2 + 1
`timescale 1ns/1ps
`include "dac_test_params.svh"
module crc16_engine
(
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    crc_if.engine     eng
);

    dac_test_pkg::crc_word_t acc;
    dac_test_pkg::crc_word_t next_acc;
    logic                    fb;

    // next remainder: clear beats shift
    always_comb
    begin
        fb       = acc[15] ^ eng.din;
        next_acc = acc;
        if (eng.clear)
        begin
            next_acc = `CRC_SEED;
        end
        else if (eng.shift)
        begin
            next_acc = {acc[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
        end
    end

    // remainder register
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            acc <= `CRC_SEED;
        else
            acc <= next_acc;
    end

    assign eng.crc = acc;

    // ***********************************
    // assertions
    // ***********************************
    a_clear_seed: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        eng.clear |=> acc == `CRC_SEED)
        else $error("accumulator not cleared");

    a_shift_poly: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (eng.shift && !eng.clear) |=>
        acc == ({$past(acc[14:0]), 1'b0}
                ^ (($past(acc[15]) ^ $past(eng.din)) ? `CRC_POLY : 16'h0000)))
        else $error("bad polynomial step");

    a_hold_idle: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!eng.shift && !eng.clear) |=> $stable(acc))
        else $error("accumulator moved while idle");

endmodule : crc16_engine

/* File: hdl/crc_if.sv */
// link between the test controller and the checksum engine
`timescale 1ns/1ps
interface crc_if;
    logic                   shift;
    logic                   clear;
    logic                   din;
    dac_test_pkg::crc_word_t crc;

    modport ctrl   (output shift, output clear, output din, input crc);
    modport engine (input shift, input clear, input din, output crc);
endinterface : crc_if

/* File: hdl/dac_crc_sense_test.sv */
// dac data checksum, colour sense capture and id register
`timescale 1ns/1ps
`include "dac_test_params.svh"
module dac_crc_sense_test
#(
    parameter logic [7:0] ID_CODE = 8'h5a // arbitrary value
)
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] reg_index_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [7:0] red_data_i,
    input  wire logic [7:0] green_data_i,
    input  wire logic [7:0] blue_data_i,
    input  wire logic       mux_control_two_bit7_i,
    input  wire logic       system_blank_in_n_i,
    input  wire logic       legacy_blank_in_n_i,
    input  wire logic       system_hsync_in_n_i,
    input  wire logic       legacy_hsync_in_n_i,
    input  wire logic       vert_sync_n_i,
    input  wire logic       red_over_i,
    input  wire logic       green_over_i,
    input  wire logic       blue_over_i,
    output logic            sense_n_o
);

    // ***********************************
    // pin synchronisers
    // ***********************************
    localparam int NSYNC = 8;
    localparam logic [NSYNC-1:0] SYNC_RST = `SYNC_RST_VAL; // blanks reset low
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;

    assign pins = {system_blank_in_n_i, legacy_blank_in_n_i,
                   system_hsync_in_n_i, legacy_hsync_in_n_i,
                   vert_sync_n_i, red_over_i, green_over_i, blue_over_i};

    // two flops per pin
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    sync1[g] <= SYNC_RST[g];
                    sync2[g] <= SYNC_RST[g];
                end
                else
                begin
                    sync1[g] <= pins[g];
                    sync2[g] <= sync1[g];
                end
            end
        end
    endgenerate

    // ***********************************
    // internal blank and sync selection
    // ***********************************
    logic       blank_n;
    logic       hsync_n;
    logic       blank_n_d;
    logic       hsync_n_d;
    logic       blank_fall;
    logic       hsync_rise;
    logic       retrace;
    logic [2:0] over;

    // mode picks legacy or system video control
    assign blank_n = mux_control_two_bit7_i ? sync2[6] : sync2[7];
    assign hsync_n = mux_control_two_bit7_i ? sync2[4] : sync2[5];
    assign retrace = !sync2[3];
    assign over    = sync2[2:0];

    // edge history
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            blank_n_d <= 1'b0; // no false blank edge at release
            hsync_n_d <= 1'b1;
        end
        else
        begin
            blank_n_d <= blank_n;
            hsync_n_d <= hsync_n;
        end
    end

    assign blank_fall = blank_n_d && !blank_n;
    assign hsync_rise = !hsync_n_d && hsync_n;

    // ***********************************
    // software registers
    // ***********************************
    logic [4:0]  line_sel;
    logic [4:0]  next_line_sel;
    logic        sense_dis;
    logic        next_sense_dis;
    logic [7:0]  next_rdata;
    logic [2:0]  sense_res;
    logic [15:0] crc_hold;

    // writes: only line select and the disable bit are stored
    always_comb
    begin
        next_line_sel  = line_sel;
        next_sense_dis = sense_dis;
        if (reg_wr_i)
        begin
            if (reg_index_i == `LINE_SEL_IDX)
                next_line_sel = reg_wdata_i[4:0];
            else if (reg_index_i == `SENSE_IDX)
                next_sense_dis = reg_wdata_i[`SENSE_DIS_BIT];
        end
    end

    // read mux, unmapped indices read zero
    always_comb
    begin
        next_rdata = reg_rdata_o;
        if (reg_rd_i)
        begin
            if (reg_index_i == `LINE_SEL_IDX)
                next_rdata = {3'h0, line_sel};
            else if (reg_index_i == `LOW_BYTE_IDX)
                next_rdata = crc_hold[7:0];
            else if (reg_index_i == `HIGH_BYTE_IDX)
                next_rdata = crc_hold[15:8];
            else if (reg_index_i == `SENSE_IDX)
                next_rdata = {sense_dis, 4'h0, sense_res};
            else if (reg_index_i == `ID_IDX)
                next_rdata = ID_CODE;
            else
                next_rdata = 8'h00;
        end
    end

    // register bank
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            line_sel    <= `LINE_SEL_RST;
            sense_dis   <= `SENSE_DIS_RST;
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            line_sel    <= next_line_sel;
            sense_dis   <= next_sense_dis;
            reg_rdata_o <= next_rdata;
        end
    end

    // ***********************************
    // sense capture
    // ***********************************
    logic [2:0] next_sense_res;
    logic       next_sense_n;

    // latch comparators on blank falling edge
    always_comb
    begin
        next_sense_res = sense_res;
        next_sense_n   = sense_n_o;
        if (blank_fall)
        begin
            next_sense_res = sense_dis ? 3'h0 : over;
            next_sense_n   = sense_dis ? 1'b1 : !(|over);
        end
    end

    // sense state
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sense_res <= `SENSE_RES_RST;
            sense_n_o <= 1'b1;
        end
        else
        begin
            sense_res <= next_sense_res;
            sense_n_o <= next_sense_n;
        end
    end

    // ***********************************
    // line select and checksum control
    // ***********************************
    logic [23:0] lines;
    logic        sel_bit;
    logic [1:0]  bit_pipe;
    logic [1:0]  next_bit_pipe;
    dac_test_pkg::retrace_state_t rt_state;
    dac_test_pkg::retrace_state_t next_rt_state;
    logic        transfer;
    logic [15:0] next_crc_hold;
    crc_if       ifc ();

    // red at 0, green at 8, blue at 16, lsb first
    assign lines   = {blue_data_i, green_data_i, red_data_i};
    assign sel_bit = (line_sel <= `LAST_LINE) ? lines[line_sel] : 1'b0;

    // delay data to match the synchronised blank
    always_comb
    begin
        next_bit_pipe = {bit_pipe[0], sel_bit};
    end

    // second hsync rise inside retrace triggers transfer
    always_comb
    begin
        next_rt_state = rt_state;
        transfer      = 1'b0;
        case (rt_state)
            dac_test_pkg::RT_WAIT:
                if (retrace && hsync_rise)
                    next_rt_state = dac_test_pkg::RT_FIRST;
            dac_test_pkg::RT_FIRST:
                if (!retrace)
                    next_rt_state = dac_test_pkg::RT_WAIT;
                else if (hsync_rise)
                begin
                    transfer      = 1'b1;
                    next_rt_state = dac_test_pkg::RT_DONE;
                end
            dac_test_pkg::RT_DONE:
                if (!retrace)
                    next_rt_state = dac_test_pkg::RT_WAIT;
            default:
                next_rt_state = dac_test_pkg::RT_WAIT;
        endcase
        next_crc_hold = transfer ? ifc.crc : crc_hold;
    end

    // control state
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rt_state <= dac_test_pkg::RT_WAIT;
            crc_hold <= `CRC_SEED;
            bit_pipe <= 2'b00;
        end
        else
        begin
            rt_state <= next_rt_state;
            crc_hold <= next_crc_hold;
            bit_pipe <= next_bit_pipe;
        end
    end

    assign ifc.din   = bit_pipe[1];
    assign ifc.shift = blank_n;
    assign ifc.clear = transfer;

    crc16_engine u_engine
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .eng       (ifc.engine)
    );

    // ***********************************
    // assertions
    // ***********************************
    a_sense_pin_low: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (blank_fall && !sense_dis && (|over)) |=> !sense_n_o)
        else $error("sense pin not low");

    a_sense_capture: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (blank_fall && !sense_dis) |=> sense_res == $past(over))
        else $error("sense bits not captured");

    a_sense_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !blank_fall |=> $stable(sense_res) && $stable(sense_n_o))
        else $error("sense moved without blank edge");

    a_sense_disabled: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (blank_fall && sense_dis) |=> sense_res == 3'h0 && sense_n_o)
        else $error("disabled sense reported");

    a_sense_read: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_index_i == `SENSE_IDX) |=>
        reg_rdata_o == {$past(sense_dis), 4'h0, $past(sense_res)})
        else $error("sense read layout wrong");

    a_id_read: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_index_i == `ID_IDX) |=> reg_rdata_o == ID_CODE)
        else $error("id read wrong");

    a_transfer_word: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        transfer |=> crc_hold == $past(ifc.crc) && ifc.crc == `CRC_SEED)
        else $error("transfer failed");

    a_transfer_cause: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        transfer |-> retrace && hsync_rise && rt_state == dac_test_pkg::RT_FIRST)
        else $error("transfer without second hsync");

    a_blank_pause: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!blank_n && !transfer) |=> $stable(ifc.crc))
        else $error("shift during blank");

    a_line_decode: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (line_sel == `BLUE_BASE) |-> sel_bit == blue_data_i[0])
        else $error("line decode wrong");

    c_transfer:   cover property (@(posedge ref_clk_i) transfer);
    c_sense_hit:  cover property (@(posedge ref_clk_i)
                                  blank_fall && !sense_dis && (|over));
    c_sense_off:  cover property (@(posedge ref_clk_i)
                                  blank_fall && sense_dis);
    c_green_line: cover property (@(posedge ref_clk_i)
                                  ifc.shift && line_sel == `GREEN_BASE);

endmodule : dac_crc_sense_test

/* File: hdl/dac_test_params.svh */
// constants for the dac checksum and sense test block
`ifndef DAC_TEST_PARAMS_SVH
`define DAC_TEST_PARAMS_SVH

// ***********************************
// indirect register indices
// ***********************************
`define LINE_SEL_IDX   8'h2c
`define LOW_BYTE_IDX   8'h2d
`define HIGH_BYTE_IDX  8'h2e
`define SENSE_IDX      8'h2f
`define ID_IDX         8'h3f

// ***********************************
// field positions and reset values
// ***********************************
`define SENSE_DIS_BIT  7
`define LINE_SEL_RST   5'h00
`define SENSE_DIS_RST  1'b0
`define SENSE_RES_RST  3'h0
`define SYNC_RST_VAL   8'h3f

// ***********************************
// checksum constants
// ***********************************
`define CRC_POLY       16'h8005
`define CRC_SEED       16'h0000
`define GREEN_BASE     5'h08
`define BLUE_BASE      5'h10
`define LAST_LINE      5'h17

`endif

/* File: hdl/dac_test_pkg.sv */
// types shared by the dac checksum and sense test block
package dac_test_pkg;

    // retrace tracking, gray coded from wait to first to done
    typedef enum logic [1:0]
    {
        RT_WAIT  = 2'b00,
        RT_FIRST = 2'b01,
        RT_DONE  = 2'b11
    } retrace_state_t;

    typedef logic [15:0] crc_word_t;

endpackage : dac_test_pkg
